/* include/fefal_cfg.svh */
`ifndef FEFAL_CFG_SVH
`define FEFAL_CFG_SVH

// register offsets on the register port
`define FEFAL_ADDR_FLAGS 8'h00
`define FEFAL_ADDR_SUPPRESS 8'h01

// bit positions, shared by the flag and suppress registers
`define FEFAL_BIT_POWER_RESET 7
`define FEFAL_BIT_WAKE 6
`define FEFAL_BIT_AUX_FAULT 5
`define FEFAL_BIT_LINE_FAULT 4
`define FEFAL_BIT_FIELD_WARN 3
`define FEFAL_BIT_FIELD_UVLO 2
`define FEFAL_BIT_RESERVED 1
`define FEFAL_BIT_OVERTEMP 0

// reset values and masks
`define FEFAL_FLAGS_RESET 8'h80
`define FEFAL_SUPPRESS_RESET 8'h00
`define FEFAL_SUPPRESS_WMASK 8'h7D
`define FEFAL_FLAG_MASK 8'hFD
`define FEFAL_UNMAPPED_DATA 8'h00

`endif

/* include/fefal_pkg.sv */
package fefal_pkg;

    typedef logic [7:0] fefal_byte_t;

    // level inputs from the on-chip monitors, high while the condition stands
    typedef struct packed {
        logic logic_supply_uvlo;
        logic reg_corrupt;
        logic wake_detect;
        logic aux_driver_fault;
        logic line_driver_fault;
        logic field_supply_warn;
        logic field_supply_uvlo;
        logic overtemp_warn;
    } fefal_evt_s;

    // one register access per cycle from the serial port decoder
    typedef struct packed {
        logic rd;
        logic wr;
        fefal_byte_t addr;
        fefal_byte_t wdata;
    } fefal_reg_req_s;

    typedef struct packed {
        logic valid;
        fefal_byte_t data;
    } fefal_reg_rsp_s;

endpackage

/* rtl/fefal_alert_gate.sv */
`timescale 1ns/1ns
`default_nettype none
module fefal_alert_gate
    import fefal_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire fefal_pkg::fefal_byte_t nxt_flags_i,
    input wire fefal_pkg::fefal_byte_t nxt_suppress_i,
    output logic alert_b_o
);
    `include "fefal_cfg.svh"

    fefal_byte_t eff_suppress;
    logic nxt_alert_b;
    logic alert_b_ff;

    // power reset flag has no suppress bit, so its position is forced open
    assign eff_suppress = nxt_suppress_i & ~(8'h01 << `FEFAL_BIT_POWER_RESET);
    // gating the next values keeps the pin in step with the flag register
    assign nxt_alert_b = ~(|(nxt_flags_i & `FEFAL_FLAG_MASK & ~eff_suppress)); // see (R1) (R7)
    assign alert_b_o = alert_b_ff;

    // reset shows the alert low, since the power reset flag resets set
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            alert_b_ff <= 1'b0; // see (R18)
        end else begin
            alert_b_ff <= nxt_alert_b; // see (R18)
        end
    end
endmodule
`default_nettype wire

/* rtl/fefal_alert_top.sv */
// Overview of operation
// (R1) Alert asserts while any flag is set and not suppressed.
// (R2) Reading the flag register clears flags and releases alert once faults are gone.
// (R3) Flags latch on their event and hold until the next flag read.
// (R4) Power reset flag, bit 7, resets to one; other flags reset to zero.
// (R5) Logic supply undervoltage resets registers and sets the power reset flag.
// (R6) Register corruption by an outside disturbance sets the power reset flag.
// (R7) Power reset flag always drives alert; it cannot be suppressed.
// (R8) Bit 6 sets on a detected wake-up request on the line.
// (R9) Bit 5 sets on auxiliary driver overload or thermal shutdown.
// (R10) Bit 4 sets on line driver overload or thermal shutdown.
// (R11) Bit 3 sets when field supply falls below the 16V warning level.
// (R12) Bit 2 sets on field supply undervoltage only while the converter is off.
// (R13) Field undervoltage with converter on resets every register to default.
// (R14) Bit 0 sets when die temperature passes the warning threshold.
// (R15) Suppress register is read/write, resets to zero, set bit silences alert.
// (R16) Suppress bits gate only the alert; flags latch regardless.
// (R17) Suppress bits line up with flag bits; one means suppressed.
// (R18) Alert output is active low, low while an unsuppressed flag is set.
// (R19) Bit 1 of both registers reads zero and ignores writes.
`timescale 1ns/1ns
`default_nettype none
module fefal_alert_top
    import fefal_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire fefal_pkg::fefal_evt_s evt_i,
    input wire logic converter_off_i,
    input wire fefal_pkg::fefal_reg_req_s reg_req_i,
    output fefal_pkg::fefal_reg_rsp_s reg_rsp_o,
    output logic alert_b_o,
    output logic regs_reset_o
);
    import fefal_pkg::*;
    `include "fefal_cfg.svh"

    // bit positions and masks in the header assume byte wide registers
    if ($bits(fefal_byte_t) != 8) begin : g_byte_check
        $error("register width must be eight bits");
    end

    // decoded register accesses
    wire logic rd_flags;
    wire logic rd_suppress;
    wire logic wr_suppress;
    wire logic clear_regs;
    wire fefal_byte_t set_vec;
    wire fefal_byte_t clr_vec;
    wire fefal_byte_t flags_q;
    wire fefal_byte_t nxt_flags;
    wire fefal_byte_t rd_data;

    fefal_byte_t suppress_ff;
    fefal_byte_t nxt_suppress;
    fefal_reg_rsp_s rsp_ff;
    logic regs_reset_ff;

    function automatic fefal_byte_t bit_at(input logic val, input int pos);
        fefal_byte_t res;
        res = 8'h00;
        res[pos[2:0]] = val;
        return res;
    endfunction

    assign rd_flags = reg_req_i.rd && (reg_req_i.addr == `FEFAL_ADDR_FLAGS);
    assign rd_suppress = reg_req_i.rd && (reg_req_i.addr == `FEFAL_ADDR_SUPPRESS);
    assign wr_suppress = reg_req_i.wr && (reg_req_i.addr == `FEFAL_ADDR_SUPPRESS);

    // logic supply loss, or field supply loss with the converter on, brings every register back to its default
    assign clear_regs = evt_i.logic_supply_uvlo ||
                        (evt_i.field_supply_uvlo && !converter_off_i); // see (R5) (R13)

    // monitor levels map onto flag positions; a standing fault keeps re-setting
    assign set_vec = bit_at(evt_i.reg_corrupt, `FEFAL_BIT_POWER_RESET) // see (R6)
                   | bit_at(evt_i.wake_detect, `FEFAL_BIT_WAKE) // see (R8)
                   | bit_at(evt_i.aux_driver_fault, `FEFAL_BIT_AUX_FAULT) // see (R9)
                   | bit_at(evt_i.line_driver_fault, `FEFAL_BIT_LINE_FAULT) // see (R10)
                   | bit_at(evt_i.field_supply_warn, `FEFAL_BIT_FIELD_WARN) // see (R11)
                   | bit_at(evt_i.field_supply_uvlo && converter_off_i,
                            `FEFAL_BIT_FIELD_UVLO) // see (R12)
                   | bit_at(evt_i.overtemp_warn, `FEFAL_BIT_OVERTEMP); // see (R14)

    // a flag read clears everything; a live event wins inside the latch
    assign clr_vec = rd_flags ? 8'hFF : 8'h00; // see (R2) (R3)

    // suppress write never touches the flags, it only feeds the alert gate
    assign nxt_suppress = clear_regs ? `FEFAL_SUPPRESS_RESET :
                          wr_suppress ? (reg_req_i.wdata & `FEFAL_SUPPRESS_WMASK) :
                          suppress_ff; // see (R15) (R16) (R17) (R19)

    // unmapped reads return zero rather than stale data
    assign rd_data = rd_flags ? flags_q :
                     rd_suppress ? suppress_ff :
                     `FEFAL_UNMAPPED_DATA;

    fefal_flag_latch #(
        .WIDTH(8),
        .RESET_VAL(`FEFAL_FLAGS_RESET)
    ) u_flags (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .load_default_i(clear_regs), // see (R4) (R5) (R13)
        .clear_i(clr_vec),
        .set_i(set_vec & `FEFAL_FLAG_MASK), // see (R19)
        .q_o(flags_q),
        .nxt_o(nxt_flags)
    );

    fefal_alert_gate u_alert (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .nxt_flags_i(nxt_flags),
        .nxt_suppress_i(nxt_suppress),
        .alert_b_o(alert_b_o)
    );

    // suppress register
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            suppress_ff <= `FEFAL_SUPPRESS_RESET; // see (R15)
        end else begin
            suppress_ff <= nxt_suppress;
        end
    end

    // read answer, a one-cycle pulse after the request with pre-clear data
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff <= '{valid: reg_req_i.rd, data: rd_data};
        end
    end

    // tells the other register blocks that a supply reset is in force
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            regs_reset_ff <= 1'b0;
        end else begin
            regs_reset_ff <= clear_regs; // see (R13)
        end
    end

    assign reg_rsp_o = rsp_ff;
    assign regs_reset_o = regs_reset_ff;

    // checks on the flag, suppress and alert behaviour
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    fefal_byte_t eff_supp;
    assign eff_supp = suppress_ff & ~(8'h01 << `FEFAL_BIT_POWER_RESET);

    alert_follows_flags_a: assert property ( // see (R1) (R18)
        alert_b_o == !(|(flags_q & ~eff_supp)))
        else $error("alert pin disagrees with unsuppressed flags");

    power_reset_alert_a: assert property ( // see (R7)
        flags_q[`FEFAL_BIT_POWER_RESET] |-> !alert_b_o)
        else $error("power reset flag set but alert released");

    read_clears_a: assert property ( // see (R2)
        (rd_flags && (evt_i == '0)) |=> (flags_q == 8'h00) && alert_b_o)
        else $error("quiet flag read did not clear flags and release alert");

    read_data_a: assert property ( // see (R2)
        rd_flags |=> reg_rsp_o.valid && (reg_rsp_o.data == $past(flags_q)))
        else $error("flag read returned wrong data");

    flag_holds_a: assert property ( // see (R3)
        (!rd_flags && !clear_regs) |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
        else $error("flag dropped without a read");

    event_latches_a: assert property ( // see (R8) (R9) (R10) (R11) (R14) (R16)
        (!clear_regs && (set_vec != 8'h00)) |=>
            ((flags_q & $past(set_vec) & `FEFAL_FLAG_MASK) ==
             ($past(set_vec) & `FEFAL_FLAG_MASK)))
        else $error("event did not latch its flag");

    supply_reset_a: assert property ( // see (R5) (R13)
        clear_regs |=> (flags_q == `FEFAL_FLAGS_RESET) && (suppress_ff == 8'h00)
                       && regs_reset_o)
        else $error("supply reset did not restore defaults");

    corrupt_sets_a: assert property ( // see (R6)
        evt_i.reg_corrupt |=> flags_q[`FEFAL_BIT_POWER_RESET])
        else $error("corruption did not set power reset flag");

    uvlo_flag_a: assert property ( // see (R12)
        (evt_i.field_supply_uvlo && converter_off_i && !clear_regs) |=>
            flags_q[`FEFAL_BIT_FIELD_UVLO] && !regs_reset_o)
        else $error("undervoltage flag missing with converter off");

    suppress_write_a: assert property ( // see (R15) (R17)
        (wr_suppress && !clear_regs) |=>
            suppress_ff == ($past(reg_req_i.wdata) & `FEFAL_SUPPRESS_WMASK))
        else $error("suppress write not stored");

    reserved_zero_a: assert property ( // see (R19)
        !flags_q[`FEFAL_BIT_RESERVED] && !suppress_ff[`FEFAL_BIT_RESERVED])
        else $error("reserved bit read as one");

    // answers pulse only for reads, so a host polling valid never sees a write echo
    read_only_answer_a: assert property ( // see (R2)
        !reg_req_i.rd |=> !reg_rsp_o.valid)
        else $error("answer pulse without a read");

    suppress_read_a: assert property ( // see (R15)
        rd_suppress |=> reg_rsp_o.valid && (reg_rsp_o.data == $past(suppress_ff)))
        else $error("suppress read returned wrong data");

    // flags, events and reads must leave the suppress bits alone
    suppress_holds_a: assert property ( // see (R15) (R16)
        (!wr_suppress && !clear_regs) |=> $stable(suppress_ff))
        else $error("suppress register changed without a write");

    // the flag register has no write path, so a write must not disturb it
    flag_write_ignored_a: assert property ( // see (R3)
        (reg_req_i.wr && (reg_req_i.addr == `FEFAL_ADDR_FLAGS) && !rd_flags &&
         !clear_regs && (set_vec == 8'h00)) |=> $stable(flags_q))
        else $error("flag register changed on a write");

    // the reset indication must not linger once the supply is back
    reset_out_quiet_a: assert property ( // see (R13)
        !clear_regs |=> !regs_reset_o)
        else $error("supply reset shown with no supply loss");

    alert_service_c: cover property (
        !alert_b_o ##1 rd_flags ##1 alert_b_o);
    suppressed_flag_c: cover property (
        flags_q[`FEFAL_BIT_WAKE] && suppress_ff[`FEFAL_BIT_WAKE] && alert_b_o);
    converter_reset_c: cover property (
        evt_i.field_supply_uvlo && !converter_off_i ##1 regs_reset_o);
    set_beats_clear_c: cover property (
        rd_flags && evt_i.line_driver_fault ##1 flags_q[`FEFAL_BIT_LINE_FAULT]);
    corrupt_unmasked_c: cover property (
        evt_i.reg_corrupt && (suppress_ff == `FEFAL_SUPPRESS_WMASK) ##1 !alert_b_o);

endmodule
`default_nettype wire

/* rtl/fefal_flag_latch.sv */
`timescale 1ns/1ns
`default_nettype none
module fefal_flag_latch #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic load_default_i,
    input wire logic [WIDTH-1:0] clear_i,
    input wire logic [WIDTH-1:0] set_i,
    output logic [WIDTH-1:0] q_o,
    output logic [WIDTH-1:0] nxt_o
);
    // a zero width latch has nothing to hold, so refuse it while elaborating
    if (WIDTH < 1) begin : g_width_check
        $error("flag latch width must be at least one");
    end

    logic [WIDTH-1:0] flags_ff;

    // set wins over clear so an event in the clearing cycle survives
    assign nxt_o = load_default_i ? RESET_VAL : ((flags_ff & ~clear_i) | set_i);
    assign q_o = flags_ff;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_ff <= RESET_VAL;
        end else begin
            flags_ff <= nxt_o;
        end
    end
endmodule
`default_nettype wire

/* tb/fefal_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// host side of the register port, one access at a time
module fefal_host_model (
    input wire logic ref_clk_i,
    input wire fefal_pkg::fefal_reg_rsp_s reg_rsp_i,
    output fefal_pkg::fefal_reg_req_s reg_req_o
);
    import fefal_pkg::*;

    initial reg_req_o = '0;

    // an idle cycle comes before each request, so back to back calls never
    // assign the strobes twice in one time step
    task automatic access(input logic r, input logic w, input fefal_byte_t a,
                          input fefal_byte_t d, output fefal_reg_rsp_s rsp);
        @(posedge ref_clk_i);
        #1;
        reg_req_o = {r, w, a, d};
        @(posedge ref_clk_i);
        #1;
        rsp = reg_rsp_i;
        // released fields flip so nothing leans on stale values
        reg_req_o = {2'h0, ~reg_req_o.addr, ~reg_req_o.wdata};
    endtask
endmodule
`default_nettype wire

/* tb/tb_fault_event_flag_and_alert_logic.sv */
`timescale 1ns/1ns
`default_nettype none
`include "fefal_cfg.svh"
module tb_fault_event_flag_and_alert_logic;
    import fefal_pkg::*;

    // one stimulus row: event, converter off, suppress, flags, alert level, supply reset
    typedef struct packed {
        fefal_byte_t evt;
        logic off;
        fefal_byte_t sup;
        fefal_byte_t flags;
        logic alert_b;
        logic regs_rst;
    } fefal_row_s;

    logic ref_clk_i;
    logic rst_b_i;
    fefal_evt_s evt;
    logic conv_off;
    fefal_reg_req_s req;
    fefal_reg_rsp_s rsp;
    fefal_reg_rsp_s got;
    logic alert_b;
    logic regs_rst;
    int mismatches = 0;
    int compares = 0;
    int cycles = 0;
    fefal_row_s rows [12] = '{
        '{8'h20, 1'h0, 8'h00, 8'h40, 1'h0, 1'h0},
        '{8'h20, 1'h0, 8'h40, 8'h40, 1'h1, 1'h0},
        '{8'h10, 1'h0, 8'h00, 8'h20, 1'h0, 1'h0},
        '{8'h10, 1'h0, 8'h20, 8'h20, 1'h1, 1'h0},
        '{8'h08, 1'h0, 8'h00, 8'h10, 1'h0, 1'h0},
        '{8'h08, 1'h0, 8'h10, 8'h10, 1'h1, 1'h0},
        '{8'h04, 1'h0, 8'h00, 8'h08, 1'h0, 1'h0},
        '{8'h02, 1'h1, 8'h00, 8'h04, 1'h0, 1'h0},
        '{8'h01, 1'h0, 8'h01, 8'h01, 1'h1, 1'h0},
        '{8'h02, 1'h0, 8'h7D, 8'h80, 1'h0, 1'h1},
        '{8'h80, 1'h0, 8'h7D, 8'h80, 1'h0, 1'h1},
        '{8'h40, 1'h0, 8'h7D, 8'h80, 1'h0, 1'h0}
    };

    fefal_alert_top u_fefal_alert_top (
        .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .evt_i(evt),
        .converter_off_i(conv_off), .reg_req_i(req), .reg_rsp_o(rsp),
        .alert_b_o(alert_b), .regs_reset_o(regs_rst)
    );

    fefal_host_model u_fefal_host_model (
        .ref_clk_i(ref_clk_i), .reg_rsp_i(rsp), .reg_req_o(req)
    );

    initial begin
        ref_clk_i = 1'h0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // whole run is about 130 cycles; the ceiling at 1500 leaves ample margin
    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 1500) begin
            mismatches++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk(input fefal_byte_t seen, input fefal_byte_t exp, input string msg);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h want %h", $time, msg, seen, exp);
        end
    endtask

    task automatic chk_alert(input logic exp, input string msg);
        chk({7'h00, alert_b}, {7'h00, exp}, msg);
    endtask

    task automatic rd(input fefal_byte_t a, input fefal_byte_t exp);
        u_fefal_host_model.access(1'h1, 1'h0, a, 8'h00, got);
        chk({7'h00, got.valid}, 8'h01, "read answer");
        chk(got.data, exp, "read data");
    endtask

    task automatic wr(input fefal_byte_t a, input fefal_byte_t d);
        u_fefal_host_model.access(1'h0, 1'h1, a, d, got);
        chk({7'h00, got.valid}, 8'h00, "write answer");
    endtask

    initial begin
        evt = '0;
        conv_off = 1'h0;
        rst_b_i = 1'h0;
        tick(2);
        chk_alert(1'h0, "alert in reset");
        rst_b_i = 1'h1;
        rd(`FEFAL_ADDR_FLAGS, `FEFAL_FLAGS_RESET);
        rd(`FEFAL_ADDR_SUPPRESS, `FEFAL_SUPPRESS_RESET);
        $display("test reset done");
        // one event pulse per row, then the host services the alert
        foreach (rows[i]) begin
            wr(`FEFAL_ADDR_SUPPRESS, rows[i].sup);
            evt = rows[i].evt;
            conv_off = rows[i].off;
            tick(1);
            evt = '0;
            chk({7'h00, regs_rst}, {7'h00, rows[i].regs_rst}, "reset out");
            tick(3);
            chk_alert(rows[i].alert_b, "alert level");
            rd(`FEFAL_ADDR_FLAGS, rows[i].flags);
            chk_alert(1'h1, "alert after read");
            $display("test row %0d done", i);
        end
        // a fault still standing keeps its flag through a read; last row left bit 4 suppressed
        wr(`FEFAL_ADDR_SUPPRESS, 8'h00);
        evt = 8'h08;
        rd(`FEFAL_ADDR_FLAGS, 8'h10);
        chk_alert(1'h0, "alert with fault held");
        evt = '0;
        rd(`FEFAL_ADDR_FLAGS, 8'h10);
        rd(`FEFAL_ADDR_FLAGS, 8'h00);
        $display("test standing fault done");
        // reserved bits, writes to the flag register, unmapped address
        wr(`FEFAL_ADDR_SUPPRESS, 8'hFF);
        rd(`FEFAL_ADDR_SUPPRESS, `FEFAL_SUPPRESS_WMASK);
        conv_off = 1'h1;
        evt = 8'h3F;
        tick(1);
        evt = '0;
        chk_alert(1'h1, "all suppressed");
        wr(`FEFAL_ADDR_FLAGS, 8'h00);
        rd(`FEFAL_ADDR_FLAGS, 8'h7D);
        rd(8'h05, `FEFAL_UNMAPPED_DATA);
        $display("test awkward done");
        // reset in mid-run brings back the power reset flag and clears suppress
        rst_b_i = 1'h0;
        tick(1);
        chk_alert(1'h0, "alert in second reset");
        rst_b_i = 1'h1;
        rd(`FEFAL_ADDR_SUPPRESS, `FEFAL_SUPPRESS_RESET);
        rd(`FEFAL_ADDR_FLAGS, `FEFAL_FLAGS_RESET);
        chk_alert(1'h1, "alert after second reset read");
        $display("test second reset done");
        complete_run();
    end
endmodule
`default_nettype wire
